/* rtl/hpm_top.sv */
/*
  Host port pin function mux: assigns the shared host pins to the
  8080-style bus, the parallel RGB bus or the three-wire serial link,
  from the interface straps caught after reset.
  Assumes clk_sys_i at 40 MHz, rgb_pclk_i from the video source, core
  logic on clk_sys_i behind the host_* and pix_* ports.
*/
// Operation
// - inactive chip select ignores bus and serial
// - one chip select for both ports
// - 8080 carries both, RGB pixels, serial registers
// - 8080 mode: shared pins are bidirectional data
// - RGB mode: shared pins are pixel bits 17:2
// - RGB strobes are pixel bits 1,0
// - 8080 command/data select picks address or data
// - RGB mode: command/data pin is line sync
// - 8080 mode: frame-safe output follows vsync
// - RGB mode: frame-safe pin is frame sync input
// - GPIO interrupt output high on condition
// - only input-configured GPIOs raise interrupts
// - reset clears registers, outputs inactive
// - mirror clock input when mirror enabled
// - mirror output low when disabled
// - straps 11 wide bus, 01 narrow bus
// - registers byte wide except memory data port on the wide 8080 bus
`include "hpm_cfg.svh"

module hpm_top (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   rgb_pclk_i,
  input  wire logic [`HPM_BUS_W-1:0]  host_bus_lines_i,
  output logic      [`HPM_BUS_W-1:0]  host_bus_lines_o,
  output logic                        host_bus_lines_oe_o,
  input  wire logic                   wr_strobe_n_i,
  input  wire logic                   rd_strobe_n_i,
  input  wire logic                   chip_sel_n_i,
  input  wire logic                   cmd_data_sel_i,
  input  wire logic                   frame_safe_flag_i,
  output logic                        frame_safe_flag_o,
  output logic                        frame_safe_flag_oe_o,
  input  wire logic                   rgb_data_valid_i,
  input  wire logic                   ser_clk_i,
  input  wire logic                   ser_in_i,
  input  wire logic                   osc_clock_in_i,
  input  wire logic                   clock_mirror_enable_i,
  output logic                        clock_mirror_out_o,
  input  wire logic [1:0]             interface_straps_i,
  input  wire logic [`HPM_GPIO_W-1:0] gpio_pins_i,
  input  wire logic [`HPM_GPIO_W-1:0] gpio_dir_in_i,
  input  wire logic [`HPM_GPIO_W-1:0] gpio_irq_en_i,
  output logic                        gpio_int_o,
  input  wire logic                   vsync_status_i,
  input  wire logic [`HPM_BUS_W-1:0]  rd_data_i,
  output logic                        host_wr_o,
  output logic                        host_rd_o,
  output logic      [`HPM_ADDR_W-1:0] host_addr_o,
  output logic      [`HPM_BUS_W-1:0]  host_wdata_o,
  output logic                        rgb_mode_o,
  output logic                        bus_wide_o,
  output logic                        pix_valid_o,
  output logic      [`HPM_PIX_W-1:0]  pix_data_o,
  output logic                        line_sync_in_o,
  output logic                        frame_sync_in_o
);

  localparam int SYNC_W = 9 + 2 + `HPM_GPIO_W + `HPM_BUS_W + 1;

  hpm_pkg::hpm_sys_t st_reg;
  hpm_pkg::hpm_sys_t st_next;
  hpm_pkg::hpm_pix_t px_reg;
  hpm_pkg::hpm_pix_t px_next;

  logic [SYNC_W-1:0]        sync_d;
  logic [SYNC_W-1:0]        sync_q;
  logic                     cs_n_s;
  logic                     wr_n_s;
  logic                     rd_n_s;
  logic                     dc_s;
  logic                     sclk_s;
  logic                     si_s;
  logic                     fs_s;
  logic                     osc_s;
  logic                     men_s;
  logic [1:0]               straps_s;
  logic [`HPM_GPIO_W-1:0]   gpio_s;
  logic [`HPM_BUS_W-1:0]    bus_s;
  logic                     ptog_s;

  // strap decode
  function automatic hpm_pkg::hpm_mode_t mode_of(input logic [1:0] straps);
    hpm_pkg::hpm_mode_t m;
    m = hpm_pkg::MODE_RGB;
    if (straps == `HPM_STRAP_I80_16) begin
      m = hpm_pkg::MODE_I80_16;
    end else if (straps == `HPM_STRAP_I80_8) begin
      m = hpm_pkg::MODE_I80_8;
    end
    return m;
  endfunction

  // register accesses keep the low byte only, except the memory data port on a wide bus
  function automatic logic [`HPM_BUS_W-1:0] narrow(input logic [`HPM_BUS_W-1:0]  d,
                                                   input logic [`HPM_ADDR_W-1:0] a,
                                                   input logic                   wide);
    logic [`HPM_BUS_W-1:0] r;
    r = {`HPM_RST_BYTE, d[`HPM_ADDR_W-1:0]};
    if (wide && (a == `HPM_DMEM_PORT)) begin
      r = d;
    end
    return r;
  endfunction

  // every pin but the pixel clock and data valid, and the pixel toggle, pass two flip-flops
  assign sync_d = {chip_sel_n_i, wr_strobe_n_i, rd_strobe_n_i, cmd_data_sel_i,
                   ser_clk_i, ser_in_i, frame_safe_flag_i, osc_clock_in_i,
                   clock_mirror_enable_i, interface_straps_i, gpio_pins_i,
                   host_bus_lines_i, px_reg.tog};

  hpm_sync #(
    .WIDTH (SYNC_W)
  ) u_sync_sys (
    .clk_i     (clk_sys_i),
    .reset_n_i (reset_n_i),
    .d_i       (sync_d),
    .q_o       (sync_q)
  );

  assign {cs_n_s, wr_n_s, rd_n_s, dc_s, sclk_s, si_s, fs_s, osc_s, men_s,
          straps_s, gpio_s, bus_s, ptog_s} = sync_q;

  // pixel clock domain: every rising edge sampled, sys side keeps RGB mode only
  always_comb begin
    px_next     = px_reg;
    // shared pins are pixel bits 17:2
    // strobes give bits 1 and 0
    px_next.pix = {host_bus_lines_i, wr_strobe_n_i, rd_strobe_n_i};
    px_next.hs  = cmd_data_sel_i;
    px_next.vs  = frame_safe_flag_i;
    px_next.de  = rgb_data_valid_i;
    px_next.tog = ~px_reg.tog;
  end

  always_ff @(posedge rgb_pclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      px_reg <= '0;
    end else begin
      px_reg <= px_next;
    end
  end

  // system clock domain
  always_comb begin
    st_next           = st_reg;
    st_next.host_wr   = 1'b0;
    st_next.host_rd   = 1'b0;
    st_next.pix_valid = 1'b0;
    st_next.wr_n_d    = wr_n_s;
    st_next.rd_n_d    = rd_n_s;
    st_next.sclk_d    = sclk_s;
    st_next.ptog_d    = ptog_s;
    st_next.bus_d     = bus_s;

    if (!st_reg.mode_ok) begin
      if (st_reg.settle == `HPM_STRAP_SETTLE) begin
        st_next.mode_ok = 1'b1;
        st_next.mode    = mode_of(straps_s);
        st_next.rgb     = (mode_of(straps_s) == hpm_pkg::MODE_RGB);
        st_next.wide    = (mode_of(straps_s) == hpm_pkg::MODE_I80_16);
      end else begin
        st_next.settle = st_reg.settle + 2'h1;
      end
    end

    st_next.bus_oe  = 1'b0;
    st_next.fs_oe   = 1'b0;
    st_next.fs_out  = 1'b0;
    st_next.bus_out = `HPM_RST_WORD;

    if (st_reg.mode_ok && !st_reg.rgb) begin
      // low select is address, high is data
      if (!st_reg.wr_n_d && wr_n_s && !cs_n_s) begin
        if (!dc_s) begin
          st_next.addr = st_reg.bus_d[`HPM_ADDR_W-1:0];
        end else begin
          st_next.host_wr = 1'b1;
          // upper byte only for memory port
          st_next.wdata   = narrow(st_reg.bus_d, st_reg.addr, st_reg.wide);
        end
      end
      if (st_reg.rd_n_d && !rd_n_s && !cs_n_s && dc_s) begin
        st_next.host_rd = 1'b1;
      end
      st_next.bus_oe  = !cs_n_s && !rd_n_s;
      st_next.bus_out = narrow(rd_data_i, st_reg.addr, st_reg.wide);
      st_next.fs_oe   = 1'b1;
      st_next.fs_out  = vsync_status_i;
    end

    if (st_reg.mode_ok && st_reg.rgb && !cs_n_s) begin
      if (!st_reg.sclk_d && sclk_s) begin
        st_next.ser_sh = {st_reg.ser_sh[`HPM_BUS_W-2:0], si_s};
        if (st_reg.ser_cnt == `HPM_SER_BITS - 5'h01) begin
          st_next.ser_cnt = '0;
          st_next.host_wr = 1'b1;
          st_next.addr    = st_next.ser_sh[`HPM_BUS_W-1:`HPM_ADDR_W];
          st_next.wdata   = {`HPM_RST_BYTE, st_next.ser_sh[`HPM_ADDR_W-1:0]};
        end else begin
          st_next.ser_cnt = st_reg.ser_cnt + 5'h01;
        end
      end
    end else begin
      st_next.ser_cnt = '0;
    end

    // pixel stream only in RGB mode
    if (st_reg.rgb && (ptog_s != st_reg.ptog_d)) begin
      st_next.pix_valid = px_reg.de;
      st_next.pix_data  = px_reg.pix;
      st_next.lsync     = px_reg.hs;
      st_next.fsync     = px_reg.vs;
    end

    st_next.gpio_int = |(gpio_s & gpio_dir_in_i & gpio_irq_en_i);

    st_next.mirror = men_s & osc_s;
  end

  // reset puts every register to its default
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_bus_lines_o     = st_reg.bus_out;
  assign host_bus_lines_oe_o  = st_reg.bus_oe;
  assign frame_safe_flag_o    = st_reg.fs_out;
  assign frame_safe_flag_oe_o = st_reg.fs_oe;
  assign clock_mirror_out_o   = st_reg.mirror;
  assign gpio_int_o           = st_reg.gpio_int;
  assign host_wr_o            = st_reg.host_wr;
  assign host_rd_o            = st_reg.host_rd;
  assign host_addr_o          = st_reg.addr;
  assign host_wdata_o         = st_reg.wdata;
  assign rgb_mode_o           = st_reg.rgb;
  assign bus_wide_o           = st_reg.wide;
  assign pix_valid_o          = st_reg.pix_valid;
  assign pix_data_o           = st_reg.pix_data;
  assign line_sync_in_o       = st_reg.lsync;
  assign frame_sync_in_o      = st_reg.fsync;

  // checks
  default clocking cb_sys @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);

  a_cs_blocks_wr : assert property (cs_n_s |=> !host_wr_o)
    else $error("write taken with chip select inactive");

  a_cs_stops_ser : assert property (cs_n_s |=> (st_reg.ser_cnt == '0))
    else $error("serial bit count moved with chip select inactive");

  a_rgb_no_drive : assert property (rgb_mode_o |-> !host_bus_lines_oe_o)
    else $error("shared bus driven in RGB mode");

  a_pix_only_rgb : assert property (!st_reg.rgb |=> !pix_valid_o)
    else $error("pixel produced outside RGB mode");

  a_reg_low_byte : assert property (
      (host_wr_o && (host_addr_o != `HPM_DMEM_PORT))
      |-> (host_wdata_o[`HPM_BUS_W-1:`HPM_ADDR_W] == `HPM_RST_BYTE))
    else $error("register write carried an upper byte");

  a_fs_follows : assert property (
      (st_reg.mode_ok && !st_reg.rgb) |=> (frame_safe_flag_oe_o
                                          && frame_safe_flag_o == $past(vsync_status_i)))
    else $error("frame-safe output not following vsync");

  a_fs_is_input : assert property (rgb_mode_o |-> !frame_safe_flag_oe_o)
    else $error("frame-safe pin driven in RGB mode");

  a_gpio_source : assert property (
      gpio_int_o |-> $past(|(gpio_s & gpio_dir_in_i & gpio_irq_en_i)))
    else $error("interrupt without an enabled input pin");

  a_mirror_low : assert property (!men_s |=> !clock_mirror_out_o)
    else $error("clock mirror high while disabled");

  a_mode_held : assert property (st_reg.mode_ok |=> (st_reg.mode_ok && $stable(st_reg.mode)))
    else $error("interface mode changed after capture");

  a_strap_wide : assert property (
      ($rose(st_reg.mode_ok)) |-> (bus_wide_o == ($past(straps_s) == `HPM_STRAP_I80_16)))
    else $error("bus width disagrees with straps");

  a_rd_needs_cs : assert property (
      host_rd_o |-> $past(!cs_n_s && dc_s && !st_reg.rgb))
    else $error("read started without chip select and data select");

  a_ser_no_read : assert property (rgb_mode_o |-> !host_rd_o)
    else $error("read started in serial mode");

  a_oe_needs_cs : assert property (
      host_bus_lines_oe_o |-> $past(!cs_n_s && !rd_n_s))
    else $error("shared bus driven outside a selected read");

  a_oe_low_byte : assert property (
      (host_bus_lines_oe_o && !bus_wide_o)
      |-> (host_bus_lines_o[`HPM_BUS_W-1:`HPM_ADDR_W] == `HPM_RST_BYTE))
    else $error("narrow bus drove an upper byte");

  a_int_raised : assert property (
      (|(gpio_s & gpio_dir_in_i & gpio_irq_en_i)) |=> gpio_int_o)
    else $error("interrupt not raised for an enabled input pin");

  a_mirror_copy : assert property (men_s |=> (clock_mirror_out_o == $past(osc_s)))
    else $error("clock mirror not following the clock input");

  a_wide_not_rgb : assert property (rgb_mode_o |-> !bus_wide_o)
    else $error("wide bus flagged in RGB mode");

  a_pix_map : assert property (@(posedge rgb_pclk_i) disable iff (!reset_n_i)
      1'b1 |=> (px_reg.pix == {$past(host_bus_lines_i), $past(wr_strobe_n_i),
                               $past(rd_strobe_n_i)}))
    else $error("pixel bits not mapped from pins");

  a_sync_map : assert property (@(posedge rgb_pclk_i) disable iff (!reset_n_i)
      1'b1 |=> ((px_reg.hs == $past(cmd_data_sel_i))
                && (px_reg.vs == $past(frame_safe_flag_i))
                && (px_reg.de == $past(rgb_data_valid_i))))
    else $error("sync or valid bits not taken from pins");

endmodule // hpm_top

/* shared/hpm_cfg.svh */
/*
  Constants for the host port pin function mux: strap codes, register
  port address, serial frame length, pixel layout and reset values.
  Assumes it is included once by bare name from the package and modules.
*/
`ifndef HPM_CFG_SVH
`define HPM_CFG_SVH

// interface strap patterns
`define HPM_STRAP_I80_16   2'h3
`define HPM_STRAP_I80_8    2'h1

// strap settle count after reset release
`define HPM_STRAP_SETTLE   2'h3

// display memory data port address, the only 16-bit register access
`define HPM_DMEM_PORT      8'ha0

// serial frame: address byte then data byte
`define HPM_SER_BITS       5'h10
`define HPM_SER_CNT_W      5

// widths
`define HPM_BUS_W          16
`define HPM_PIX_W          18
`define HPM_ADDR_W         8
`define HPM_GPIO_W         8

// reset values
`define HPM_RST_BYTE       8'h00
`define HPM_RST_WORD       16'h0000
`define HPM_RST_PIX        18'h00000

`endif

/* shared/hpm_pkg.sv */
/*
  Types for the host port pin function mux: interface modes and the
  packed state of each clock domain.
  Assumes hpm_cfg.svh is on the include path.
*/
`include "hpm_cfg.svh"

package hpm_pkg;

  typedef enum logic [1:0] {
    MODE_RGB,
    MODE_I80_8,
    MODE_I80_16
  } hpm_mode_t;

  typedef struct packed {
    hpm_mode_t                 mode;
    logic                      mode_ok;
    logic                      rgb;
    logic                      wide;
    logic [1:0]                settle;
    logic                      wr_n_d;
    logic                      rd_n_d;
    logic                      sclk_d;
    logic                      ptog_d;
    logic [`HPM_BUS_W-1:0]     bus_d;
    logic [`HPM_ADDR_W-1:0]    addr;
    logic                      host_wr;
    logic                      host_rd;
    logic [`HPM_BUS_W-1:0]     wdata;
    logic [`HPM_BUS_W-1:0]     bus_out;
    logic                      bus_oe;
    logic                      fs_out;
    logic                      fs_oe;
    logic [`HPM_BUS_W-1:0]     ser_sh;
    logic [`HPM_SER_CNT_W-1:0] ser_cnt;
    logic                      gpio_int;
    logic                      mirror;
    logic                      pix_valid;
    logic [`HPM_PIX_W-1:0]     pix_data;
    logic                      lsync;
    logic                      fsync;
  } hpm_sys_t;

  typedef struct packed {
    logic                      tog;
    logic                      de;
    logic                      hs;
    logic                      vs;
    logic [`HPM_PIX_W-1:0]     pix;
  } hpm_pix_t;

endpackage : hpm_pkg

/* rtl/hpm_sync.sv */
/*
  Two flip-flop level synchroniser, parameterised width.
  Assumes the destination clock and an asynchronous active-low reset.
*/
module hpm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] safe;
  } hpm_sync_t;

  hpm_sync_t st_reg;
  hpm_sync_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.meta = d_i;
    st_next.safe = st_reg.meta;
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.safe;

endmodule // hpm_sync

/* dv/hpm_host_model.sv */
/*
  Far-side model: 8080 bus master, RGB video source and serial link master.
  Assumes the bench gives clk_i and resolves the shared lines into bus_i.
*/
module hpm_host_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] bus_i,
  output logic      [15:0] bus_o,
  output logic             wr_n_o,
  output logic             rd_n_o,
  output logic             cs_n_o,
  output logic             dc_o,
  output logic             fs_o,
  output logic             de_o,
  output logic             pclk_o,
  output logic             sclk_o,
  output logic             sdi_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    bus_o = 16'h0000;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    cs_n_o = 1'b1;
    dc_o = 1'b0;
    fs_o = 1'b0;
    de_o = 1'b0;
    pclk_o = 1'b0;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wr(input logic cs, input logic dc, input logic [15:0] d);
    cs_n_o = cs;
    dc_o = dc;
    bus_o = d;
    cyc(1);
    wr_n_o = 1'b0;
    cyc(4);
    wr_n_o = 1'b1;
    cyc(3);
    cs_n_o = 1'b1;
    bus_o = ~d;
    cyc(3);
  endtask

  task automatic rd(output logic [15:0] q);
    cs_n_o = 1'b0;
    dc_o = 1'b1;
    cyc(1);
    rd_n_o = 1'b0;
    cyc(6);
    q = bus_i;
    rd_n_o = 1'b1;
    cyc(3);
    cs_n_o = 1'b1;
    cyc(1);
  endtask

  // pclk runs only inside a burst
  task automatic pix(input logic [17:0] p, input logic v, input logic hs, input logic vs);
    {bus_o, wr_n_o, rd_n_o} = p;
    de_o = v;
    dc_o = hs;
    fs_o = vs;
    #62.5 pclk_o = 1'b1;
    #62.5 pclk_o = 1'b0;
  endtask

  task automatic ser(input logic cs, input logic [15:0] f, input int n);
    cs_n_o = cs;
    cyc(3);
    for (int i = 15; i > 15 - n; i--) begin
      sdi_o = f[i];
      cyc(4);
      sclk_o = 1'b1;
      cyc(4);
      sclk_o = 1'b0;
    end
    cyc(3);
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    cyc(8);
  endtask
endmodule // hpm_host_model

/* dv/tb.sv */
/*
  Self-checking bench for the host port pin function mux.
  Assumes hpm_cfg.svh on the include path and the host model beside it.
*/
`include "hpm_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i;
  logic        reset_n_i;
  logic        osc;
  logic        mir_en;
  logic        vsync;
  logic [1:0]  straps;
  logic [7:0]  g_pin, g_dir, g_en;
  logic [15:0] bus_dut, bus_host, bus_in;
  logic        oe, fs_o, fs_oe, wr_n, rd_n, cs_n, dc, fs_h, de, pclk, sclk, sdi;
  logic        gint, mir, hwr, hrd, rgb, wide, pv, ls, fsy;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic [17:0] pdata;
  int          n_mismatch = 0, n_compared = 0, n_wr = 0, n_pix = 0, n_rd = 0;
  logic [7:0]  c_addr;
  logic [15:0] c_wdata;
  logic [17:0] c_pix;

  assign bus_in = oe ? bus_dut : bus_host;

  hpm_host_model h (.clk_i(clk_sys_i), .bus_i(bus_in), .bus_o(bus_host), .wr_n_o(wr_n),
    .rd_n_o(rd_n), .cs_n_o(cs_n), .dc_o(dc), .fs_o(fs_h), .de_o(de), .pclk_o(pclk),
    .sclk_o(sclk), .sdi_o(sdi));

  hpm_top DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .rgb_pclk_i(pclk),
    .host_bus_lines_i(bus_in), .host_bus_lines_o(bus_dut), .host_bus_lines_oe_o(oe),
    .wr_strobe_n_i(wr_n), .rd_strobe_n_i(rd_n), .chip_sel_n_i(cs_n), .cmd_data_sel_i(dc),
    .frame_safe_flag_i(fs_oe ? fs_o : fs_h), .frame_safe_flag_o(fs_o),
    .frame_safe_flag_oe_o(fs_oe), .rgb_data_valid_i(de), .ser_clk_i(sclk), .ser_in_i(sdi),
    .osc_clock_in_i(osc), .clock_mirror_enable_i(mir_en), .clock_mirror_out_o(mir),
    .interface_straps_i(straps), .gpio_pins_i(g_pin), .gpio_dir_in_i(g_dir),
    .gpio_irq_en_i(g_en), .gpio_int_o(gint), .vsync_status_i(vsync),
    .rd_data_i({addr, ~addr}), .host_wr_o(hwr), .host_rd_o(hrd), .host_addr_o(addr),
    .host_wdata_o(wdata), .rgb_mode_o(rgb), .bus_wide_o(wide), .pix_valid_o(pv),
    .pix_data_o(pdata), .line_sync_in_o(ls), .frame_sync_in_o(fsy));

  initial begin
    clk_sys_i = 1'b0;
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    osc = 1'b0;
    forever #40 osc = ~osc;
  end

  // pulses are one cycle wide, so the falling edge sees each once
  always @(negedge clk_sys_i) begin
    if (hwr === 1'b1) begin
      n_wr++;
      c_addr = addr;
      c_wdata = wdata;
    end
    if (pv === 1'b1) begin
      n_pix++;
      c_pix = pdata;
    end
    if (hrd === 1'b1) begin
      n_rd++;
    end
  end

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_n(input int g, input int e);
    n_compared++;
    if (g != e) begin
      n_mismatch++;
      $display("Error %0t: count %0d expected %0d", $time, g, e);
    end
  endtask

  task automatic rst(input logic [1:0] s);
    straps = s;
    reset_n_i = 1'b0;
    h.cyc(16);
    chk({oe, fs_oe, gint, mir, hwr, pv}, 0);
    reset_n_i = 1'b1;
    h.cyc(8);
    straps = ~s;
    h.cyc(6);
    chk({rgb, wide}, {~s[0], s == 2'h3});
    $display("reset with straps %b done", s);
  endtask

  task automatic t_write(input logic w);
    int n0;
    int n1;
    logic [15:0] q;
    n0 = n_wr;
    n1 = n_rd;
    h.wr(1'b0, 1'b0, 16'h0010);
    chk_n(n_wr, n0);
    h.wr(1'b0, 1'b1, 16'h1234);
    chk({c_addr, c_wdata}, 24'h100034);
    h.wr(1'b0, 1'b0, {8'h00, `HPM_DMEM_PORT});
    h.wr(1'b0, 1'b1, 16'habcd);
    chk(c_wdata, w ? 16'habcd : 16'h00cd);
    h.wr(1'b1, 1'b1, 16'h5555);
    chk_n(n_wr, n0 + 2);
    h.rd(q);
    chk_n(n_rd, n1 + 1);
    chk(q, w ? 16'ha05f : 16'h005f);
    chk(oe, 0);
    $display("bus test wide=%b done", w);
  endtask

  task automatic t_misc();
    int hi;
    g_pin = 8'h0f;
    g_dir = 8'h0e;
    g_en = 8'h03;
    h.cyc(5);
    chk(gint, 1);
    g_dir = 8'h0c;
    h.cyc(5);
    chk(gint, 0);
    chk(fs_oe, 1);
    vsync = 1'b1;
    h.cyc(5);
    chk(fs_o, 1);
    vsync = 1'b0;
    h.cyc(5);
    chk(fs_o, 0);
    hi = 0;
    repeat (20) begin
      h.cyc(1);
      hi += (mir === 1'b1);
    end
    chk_n(hi, 0);
    mir_en = 1'b1;
    h.cyc(4);
    hi = 0;
    repeat (20) begin
      h.cyc(1);
      hi += (mir === 1'b1);
    end
    chk_n((hi > 5) && (hi < 15), 1);
    g_dir = 8'h0e;
    h.cyc(5);
    $display("misc test done");
  endtask

  task automatic t_rgb();
    int n0;
    int n1;
    n0 = n_pix;
    n1 = n_rd;
    chk(fs_oe, 0);
    #7;
    h.pix(18'h2a5c6, 1'b1, 1'b1, 1'b0);
    h.pix(18'h15a39, 1'b1, 1'b0, 1'b1);
    h.pix(18'h3ffff, 1'b0, 1'b0, 1'b1);
    h.bus_o = ~h.bus_o;
    h.cyc(8);
    chk_n(n_pix, n0 + 2);
    chk(c_pix, 18'h15a39);
    chk({ls, fsy}, 2'h1);
    n0 = n_wr;
    h.wr(1'b0, 1'b1, 16'h7777);
    h.ser(1'b1, 16'h225c, 16);
    chk_n(n_wr, n0);
    h.ser(1'b0, 16'hffff, 8);
    h.ser(1'b0, 16'h225c, 16);
    chk_n(n_wr, n0 + 1);
    chk({c_addr, c_wdata}, 24'h22005c);
    chk_n(n_rd, n1);
    $display("rgb and serial test done");
  endtask

  task automatic end_sim();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200us;
    n_mismatch++;
    end_sim();
  end

  initial begin
    reset_n_i = 1'b0;
    mir_en = 1'b0;
    vsync = 1'b0;
    straps = 2'h3;
    g_pin = 8'h00;
    g_dir = 8'h00;
    g_en = 8'h00;
    h.cyc(1);
    rst(2'h3);
    t_write(1'b1);
    t_misc();
    rst(2'h1);
    t_write(1'b0);
    rst(2'h0);
    t_rgb();
    end_sim();
  end
endmodule // tb
